/* File: cpsf_pkg.sv */
package cpsf_pkg;
	localparam int HDR_OCTETS = 4;
	localparam int CMD_HDR_OCTETS = 4;
	localparam logic [15:0] CID_SIG = 16'h0001;
	localparam logic [15:0] CID_GRP = 16'h0002;
	localparam logic [7:0] CODE_RESERVED = 8'h00;
	localparam logic [7:0] CODE_REJECT = 8'h01;
	localparam logic [7:0] CODE_CONN_REQ = 8'h02;
	localparam logic [7:0] CODE_CONN_RSP = 8'h03;
	localparam logic [7:0] CODE_CFG_REQ = 8'h04;
	localparam logic [7:0] CODE_CFG_RSP = 8'h05;
	localparam logic [7:0] CODE_DISC_REQ = 8'h06;
	localparam logic [7:0] CODE_DISC_RSP = 8'h07;
	localparam logic [7:0] CODE_ECHO_REQ = 8'h08;
	localparam logic [7:0] CODE_ECHO_RSP = 8'h09;
	localparam logic [7:0] CODE_INFO_REQ = 8'h0a;
	localparam logic [7:0] CODE_INFO_RSP = 8'h0b;
	localparam logic [15:0] REASON_NOT_UNDERSTOOD = 16'h0000;
	localparam logic [15:0] REASON_SIG_LIMIT = 16'h0001;
	localparam logic [7:0] ID_ILLEGAL = 8'h00;
	localparam logic [7:0] ID_FIRST = 8'h01;
	localparam int SIG_LIMIT_DEF = 48;
	localparam int GRP_LIMIT_DEF = 670;
	localparam int GRP_PAY_MAX = 65533;
	localparam int PSM_MIN_OCTETS = 2;
	localparam int PSM_MAX_OCTETS_DEF = 4;
	localparam int CLK_FREQ_HZ = 250_000_000;
	localparam int SEC_CYCLES_DEF = CLK_FREQ_HZ;
	localparam int ID_REUSE_S = 360;
	localparam int STAMP_W = 16;
	localparam int TX_SR_OCTETS = 12;

	function automatic logic cpsf_is_req(input logic [7:0] code);
		return code inside {CODE_CONN_REQ, CODE_CFG_REQ, CODE_DISC_REQ, CODE_ECHO_REQ, CODE_INFO_REQ};
	endfunction : cpsf_is_req

	function automatic logic cpsf_is_known(input logic [7:0] code);
		return (code != CODE_RESERVED) && (code <= CODE_INFO_RSP);
	endfunction : cpsf_is_known
endpackage : cpsf_pkg

/* File: cpsf_id_ctl.sv */
`timescale 1ns/10ps
module cpsf_id_ctl #(
	parameter int SEC_CYCLES = cpsf_pkg::SEC_CYCLES_DEF
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic take_i,
	input wire logic clr_i,
	input wire logic [7:0] clr_id_i,
	input wire logic [7:0] q_id_i,
	output logic q_out_o,
	output logic [7:0] nxt_id_o,
	output logic nxt_ok_o
);
	localparam logic [cpsf_pkg::STAMP_W-1:0] REUSE = cpsf_pkg::STAMP_W'(cpsf_pkg::ID_REUSE_S);
	initial begin
		if (SEC_CYCLES < 2) $error("SEC_CYCLES too small");
	end

	logic [31:0] div_q;
	logic sec_tick;
	logic [cpsf_pkg::STAMP_W-1:0] sec_q;
	logic [255:0] out_q;
	logic [255:0] used_q;
	logic [cpsf_pkg::STAMP_W-1:0] stamp_q [256];
	logic [7:0] nxt_q;
	logic [cpsf_pkg::STAMP_W-1:0] age;

	assign sec_tick = (div_q == 32'(SEC_CYCLES - 1));
	assign age = sec_q - stamp_q[nxt_q];
	// Fresh id: not outstanding and not issued within the reuse period
	assign nxt_ok_o = !out_q[nxt_q] && (!used_q[nxt_q] || age >= REUSE);
	assign nxt_id_o = nxt_q;
	assign q_out_o = out_q[q_id_i];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_q <= '0;
			sec_q <= '0;
		end else begin
			div_q <= sec_tick ? '0 : div_q + 32'h1;
			if (sec_tick) sec_q <= sec_q + {{(cpsf_pkg::STAMP_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_q <= '0;
			used_q <= '0;
			nxt_q <= cpsf_pkg::ID_FIRST;
		end else begin
			if (clr_i) out_q[clr_id_i] <= 1'b0;
			if (take_i) begin
				out_q[nxt_q] <= 1'b1;
				used_q[nxt_q] <= 1'b1;
				// Zero never handed out
				nxt_q <= (nxt_q == 8'hff) ? cpsf_pkg::ID_FIRST : nxt_q + 8'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (take_i) stamp_q[nxt_q] <= sec_q;
	end

	property p_id_nonzero;
		@(posedge clk_i) disable iff (!rst_b_i) nxt_id_o != cpsf_pkg::ID_ILLEGAL;
	endproperty
	a_id_nonzero: assert property (p_id_nonzero) else $error("zero id offered");
endmodule : cpsf_id_ctl

/* File: cpsf_framer.sv */
`timescale 1ns/10ps
module cpsf_framer #(
	parameter int SIG_LIMIT = cpsf_pkg::SIG_LIMIT_DEF,
	parameter int GRP_LIMIT = cpsf_pkg::GRP_LIMIT_DEF,
	parameter int PSM_MAX_OCTETS = cpsf_pkg::PSM_MAX_OCTETS_DEF,
	parameter int SEC_CYCLES = cpsf_pkg::SEC_CYCLES_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_first_i,
	input wire logic rx_last_i,
	output logic pkt_start_o,
	output logic [15:0] pkt_len_o,
	output logic [15:0] pkt_cid_o,
	output logic pkt_err_o,
	output logic psm_valid_o,
	output logic [8*PSM_MAX_OCTETS-1:0] psm_value_o,
	output logic cmd_valid_o,
	output logic [7:0] cmd_code_o,
	output logic [7:0] cmd_id_o,
	output logic [15:0] cmd_len_o,
	output logic cmd_dup_o,
	output logic pay_valid_o,
	output logic [7:0] pay_data_o,
	input wire logic tx_start_i,
	input wire logic tx_cmd_i,
	input wire logic [15:0] tx_cid_i,
	input wire logic [15:0] tx_len_i,
	input wire logic [7:0] tx_code_i,
	input wire logic [7:0] tx_id_i,
	input wire logic tx_new_id_i,
	input wire logic peer_sig_big_i,
	output logic tx_accept_o,
	output logic [7:0] tx_id_o,
	input wire logic tx_body_valid_i,
	input wire logic [7:0] tx_body_i,
	output logic tx_body_ready_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	input wire logic tx_ready_i
);
	initial begin
		if (SIG_LIMIT < cpsf_pkg::SIG_LIMIT_DEF) $error("SIG_LIMIT below 48");
		if (GRP_LIMIT < 1 || GRP_LIMIT > cpsf_pkg::GRP_PAY_MAX) $error("GRP_LIMIT out of range");
		if (PSM_MAX_OCTETS < cpsf_pkg::PSM_MIN_OCTETS) $error("PSM_MAX_OCTETS too small");
	end
	localparam logic [15:0] SIG_LIM = 16'(SIG_LIMIT);
	localparam logic [15:0] GRP_LIM = 16'(GRP_LIMIT);

	logic rs1_q, rst_q;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rs1_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rst_q <= rs1_q;
		end
	end

	typedef enum logic [2:0] {R_HDR, R_PSM, R_CHDR, R_BODY, R_SKIP} cpsf_rx_e;
	cpsf_rx_e rst_d, rst_s_q;
	logic [1:0] bi_q;
	logic [31:0] sh_q;
	logic [15:0] len_q, cid_q, rcnt_q, crem_q;
	logic [2:0] pcnt_q;
	logic [15:0] grp_cnt_q;
	logic over_q, freq_q, dlv_q;
	logic [7:0] freq_id_q, lreq_id_q, lreq_code_q;
	logic lreq_v_q;
	logic rej_pend_q;
	logic [7:0] rej_id_q;
	logic [15:0] rej_reason_q;

	wire rb = rx_valid_i;
	wire [1:0] bi = rx_first_i ? 2'd0 : bi_q;
	wire cur_hdr = rx_first_i || rst_s_q == R_HDR;
	wire [31:0] sh_n = {rx_data_i, sh_q[31:8]};
	// Little-endian fields: low octet arrives first
	wire [15:0] h_len = sh_n[15:0];
	wire [15:0] h_cid = sh_n[31:16];
	wire hdr_done = rb && cur_hdr && bi == 2'd3;
	wire [15:0] rcnt_n = cur_hdr && bi == 2'd0 ? 16'h1 : rcnt_q + 16'h1;
	// Received count must match header length
	wire len_bad = rb && rx_last_i && !(hdr_done && h_len == 16'h0) &&
		(cur_hdr || rcnt_n != len_q + 16'(cpsf_pkg::HDR_OCTETS));
	wire is_sig = h_cid == cpsf_pkg::CID_SIG;
	wire is_grp = h_cid == cpsf_pkg::CID_GRP;
	wire psm_b = rb && rst_s_q == R_PSM && !rx_first_i;
	wire psm_first = pcnt_q == 3'd0;
	// First multiplexer octet odd, continuation octets odd, an even octet ends it
	wire psm_bad = psm_b && ((psm_first && !rx_data_i[0]) ||
		(!rx_data_i[0] && 32'(pcnt_q) + 1 < cpsf_pkg::PSM_MIN_OCTETS) ||
		(rx_data_i[0] && 32'(pcnt_q) + 1 >= PSM_MAX_OCTETS));
	wire psm_end = psm_b && !psm_bad && !rx_data_i[0];
	// Length counts multiplexer field plus payload; payload kept within limits
	wire [15:0] grp_pay = len_q - 16'(pcnt_q) - 16'h1;
	wire grp_ok = len_q >= 16'(cpsf_pkg::PSM_MIN_OCTETS) && grp_pay <= GRP_LIM;
	wire chdr_done = rb && rst_s_q == R_CHDR && !rx_first_i && bi_q == 2'd3;
	wire [7:0] c_code = sh_n[7:0];
	wire [7:0] c_id = sh_n[15:8];
	wire [15:0] c_len = sh_n[31:16];
	wire c_known = cpsf_pkg::cpsf_is_known(c_code);
	wire c_req = cpsf_pkg::cpsf_is_req(c_code);
	logic id_out;
	wire c_stray = c_known && !c_req && !id_out;
	wire c_rej = chdr_done && !over_q && !c_known && c_id != cpsf_pkg::ID_ILLEGAL;
	wire c_dlv = chdr_done && !over_q && c_known && !c_stray && c_id != cpsf_pkg::ID_ILLEGAL;
	wire sig_end = rb && rx_last_i && over_q && (freq_q || (chdr_done && c_req));
	wire [7:0] sig_end_id = freq_q ? freq_id_q : c_id;
	wire body_b = rb && rst_s_q == R_BODY && !rx_first_i;
	wire cmd_data = cid_q == cpsf_pkg::CID_SIG;
	wire cmd_end = body_b && cmd_data && crem_q == 16'h1;

	always_comb begin
		rst_d = rst_s_q;
		if (hdr_done) begin
			if (h_len == 16'h0) rst_d = R_HDR;
			else if (is_sig) rst_d = R_CHDR;
			else if (is_grp) rst_d = R_PSM;
			else rst_d = R_BODY;
		end else if (rb && rx_first_i) begin
			rst_d = R_HDR;
		end else if (psm_bad || (psm_end && !grp_ok)) begin
			rst_d = R_SKIP;
		end else if (psm_end) begin
			rst_d = R_BODY;
		end else if (chdr_done) begin
			rst_d = c_len == 16'h0 ? R_CHDR : R_BODY;
		end else if (cmd_end) begin
			rst_d = R_CHDR;
		end
		if (rb && rx_last_i) rst_d = R_HDR;
	end

	always_ff @(posedge clk_sys_i or negedge rst_q) begin
		if (!rst_q) begin
			rst_s_q <= R_HDR;
			bi_q <= '0;
			sh_q <= '0;
			len_q <= '0;
			cid_q <= '0;
			rcnt_q <= '0;
			crem_q <= '0;
			pcnt_q <= '0;
			over_q <= 1'b0;
			dlv_q <= 1'b0;
		end else if (rb) begin
			rst_s_q <= rst_d;
			sh_q <= sh_n;
			rcnt_q <= rcnt_n;
			// Next command header counts from its own first octet
			bi_q <= (hdr_done || chdr_done || cmd_end) ? 2'h0 : bi + 2'h1;
			if (hdr_done) begin
				len_q <= h_len;
				cid_q <= h_cid;
				pcnt_q <= '0;
				over_q <= is_sig && h_len > SIG_LIM;
				dlv_q <= !is_sig;
			end
			if (psm_b) pcnt_q <= pcnt_q + 3'd1;
			if (chdr_done) begin
				crem_q <= c_len;
				dlv_q <= c_dlv;
			end
			if (body_b) crem_q <= crem_q - 16'h1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_q) begin
		if (!rst_q) begin
			freq_q <= 1'b0;
			freq_id_q <= '0;
			lreq_v_q <= 1'b0;
			lreq_id_q <= '0;
			lreq_code_q <= '0;
		end else begin
			if (hdr_done) freq_q <= 1'b0;
			if (chdr_done && over_q && c_req && !freq_q) begin
				freq_q <= 1'b1;
				freq_id_q <= c_id;
			end
			if (c_dlv && c_req) begin
				lreq_v_q <= 1'b1;
				lreq_id_q <= c_id;
				lreq_code_q <= c_code;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_q) begin
		if (!rst_q) begin
			pkt_start_o <= 1'b0;
			pkt_len_o <= '0;
			pkt_cid_o <= '0;
			pkt_err_o <= 1'b0;
			psm_valid_o <= 1'b0;
			psm_value_o <= '0;
			cmd_valid_o <= 1'b0;
			cmd_code_o <= '0;
			cmd_id_o <= '0;
			cmd_len_o <= '0;
			cmd_dup_o <= 1'b0;
			pay_valid_o <= 1'b0;
			pay_data_o <= '0;
			grp_cnt_q <= '0;
		end else begin
			pkt_start_o <= hdr_done;
			pkt_err_o <= len_bad || psm_bad;
			psm_valid_o <= psm_end && grp_ok;
			cmd_valid_o <= c_dlv;
			pay_valid_o <= body_b && dlv_q;
			if (hdr_done) begin
				pkt_len_o <= h_len;
				pkt_cid_o <= h_cid;
				psm_value_o <= '0;
			end
			if (psm_b) psm_value_o[8*pcnt_q +: 8] <= rx_data_i;
			if (chdr_done) begin
				cmd_code_o <= c_code;
				cmd_id_o <= c_id;
				cmd_len_o <= c_len;
				cmd_dup_o <= c_req && lreq_v_q && c_id == lreq_id_q && c_code == lreq_code_q;
			end
			if (body_b) pay_data_o <= rx_data_i;
			grp_cnt_q <= psm_end ? grp_pay : grp_cnt_q;
		end
	end

	typedef enum logic [1:0] {T_IDLE, T_HDR, T_BODY} cpsf_tx_e;
	cpsf_tx_e tst_q;
	logic [7:0] sr_q [cpsf_pkg::TX_SR_OCTETS];
	logic [3:0] hn_q;
	logic [15:0] bn_q, tcnt_q, flen_q;
	logic fcmd_q;
	logic [7:0] nxt_id;
	logic nxt_ok;

	wire can_load = !tx_valid_o || tx_ready_i;
	wire take_rej = tst_q == T_IDLE && rej_pend_q;
	wire [15:0] c_frame = tx_len_i + 16'(cpsf_pkg::CMD_HDR_OCTETS);
	// Big signalling frames only once the peer is known to take them
	wire size_ok = !tx_cmd_i || c_frame <= SIG_LIM || peer_sig_big_i;
	wire id_ok = !tx_cmd_i || (tx_new_id_i ? nxt_ok : tx_id_i != cpsf_pkg::ID_ILLEGAL);
	assign tx_accept_o = tst_q == T_IDLE && !rej_pend_q && tx_start_i && size_ok && id_ok;
	// Fresh id for original requests, given id kept for responses and retries
	wire [7:0] use_id = tx_new_id_i ? nxt_id : tx_id_i;
	wire [15:0] rej_dl = rej_reason_q == cpsf_pkg::REASON_SIG_LIMIT ? 16'h2 : 16'h0;
	wire [15:0] rej_cl = rej_dl + 16'h2;
	wire [15:0] rej_pl = rej_cl + 16'(cpsf_pkg::CMD_HDR_OCTETS);
	wire sh_hdr = tst_q == T_HDR && can_load;
	assign tx_body_ready_o = tst_q == T_BODY && can_load;
	wire body_t = tx_body_ready_o && tx_body_valid_i;

	cpsf_id_ctl #(.SEC_CYCLES(SEC_CYCLES)) u_id (
		.clk_i(clk_sys_i),
		.rst_b_i(rst_q),
		.take_i(tx_accept_o && tx_cmd_i && tx_new_id_i),
		.clr_i(c_dlv && !c_req),
		.clr_id_i(c_id),
		.q_id_i(c_id),
		.q_out_o(id_out),
		.nxt_id_o(nxt_id),
		.nxt_ok_o(nxt_ok)
	);

	always_ff @(posedge clk_sys_i or negedge rst_q) begin
		if (!rst_q) begin
			rej_pend_q <= 1'b0;
			rej_id_q <= '0;
			rej_reason_q <= '0;
		end else if (c_rej || sig_end) begin
			// A new reject wins over the one being taken
			rej_pend_q <= 1'b1;
			rej_id_q <= c_rej ? c_id : sig_end_id;
			rej_reason_q <= c_rej ? cpsf_pkg::REASON_NOT_UNDERSTOOD : cpsf_pkg::REASON_SIG_LIMIT;
		end else if (take_rej) begin
			rej_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_q) begin
		if (!rst_q) begin
			tst_q <= T_IDLE;
			hn_q <= '0;
			bn_q <= '0;
			tx_id_o <= '0;
			fcmd_q <= 1'b0;
			flen_q <= '0;
			for (int i = 0; i < cpsf_pkg::TX_SR_OCTETS; i++) sr_q[i] <= '0;
		end else if (take_rej) begin
			// Header, command header, reason, size limit; all low octet first
			sr_q <= '{rej_pl[7:0], rej_pl[15:8], cpsf_pkg::CID_SIG[7:0], cpsf_pkg::CID_SIG[15:8],
				cpsf_pkg::CODE_REJECT, rej_id_q, rej_cl[7:0], rej_cl[15:8],
				rej_reason_q[7:0], rej_reason_q[15:8], SIG_LIM[7:0], SIG_LIM[15:8]};
			hn_q <= 4'(rej_pl + 16'(cpsf_pkg::HDR_OCTETS));
			bn_q <= '0;
			fcmd_q <= 1'b1;
			flen_q <= rej_pl;
			tst_q <= T_HDR;
		end else if (tx_accept_o) begin
			if (tx_cmd_i) begin
				sr_q <= '{c_frame[7:0], c_frame[15:8], cpsf_pkg::CID_SIG[7:0], cpsf_pkg::CID_SIG[15:8],
					tx_code_i, use_id, tx_len_i[7:0], tx_len_i[15:8], 8'h00, 8'h00, 8'h00, 8'h00};
				hn_q <= 4'(cpsf_pkg::HDR_OCTETS + cpsf_pkg::CMD_HDR_OCTETS);
				flen_q <= c_frame;
			end else begin
				sr_q <= '{tx_len_i[7:0], tx_len_i[15:8], tx_cid_i[7:0], tx_cid_i[15:8],
					8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
				hn_q <= 4'(cpsf_pkg::HDR_OCTETS);
				flen_q <= tx_len_i;
			end
			bn_q <= tx_len_i;
			tx_id_o <= use_id;
			fcmd_q <= tx_cmd_i;
			tst_q <= T_HDR;
		end else if (sh_hdr) begin
			for (int i = 0; i < cpsf_pkg::TX_SR_OCTETS - 1; i++) sr_q[i] <= sr_q[i+1];
			hn_q <= hn_q - 4'h1;
			if (hn_q == 4'h1) tst_q <= bn_q == 16'h0 ? T_IDLE : T_BODY;
		end else if (body_t) begin
			bn_q <= bn_q - 16'h1;
			if (bn_q == 16'h1) tst_q <= T_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_q) begin
		if (!rst_q) begin
			tx_valid_o <= 1'b0;
			tx_data_o <= '0;
			tx_last_o <= 1'b0;
			tcnt_q <= '0;
		end else if (can_load) begin
			tx_valid_o <= sh_hdr || body_t;
			tx_data_o <= sh_hdr ? sr_q[0] : tx_body_i;
			tx_last_o <= (sh_hdr && hn_q == 4'h1 && bn_q == 16'h0) || (body_t && bn_q == 16'h1);
			if (tx_valid_o) tcnt_q <= tx_last_o ? 16'h0 : tcnt_q + 16'h1;
		end
	end

	property p_sig_cid;
		@(posedge clk_sys_i) disable iff (!rst_q) tx_valid_o && fcmd_q && tcnt_q == 16'h2 |-> tx_data_o == 8'h01;
	endproperty
	a_sig_cid: assert property (p_sig_cid) else $error("command frame not on signalling channel");
	property p_tx_id;
		@(posedge clk_sys_i) disable iff (!rst_q) tx_valid_o && fcmd_q && tcnt_q == 16'h5 |-> tx_data_o != 8'h00;
	endproperty
	a_tx_id: assert property (p_tx_id) else $error("zero identifier sent");
	property p_tx_size;
		@(posedge clk_sys_i) disable iff (!rst_q)
			tx_accept_o && tx_cmd_i && !peer_sig_big_i |=> flen_q <= SIG_LIM;
	endproperty
	a_tx_size: assert property (p_tx_size) else $error("oversize signalling frame");
	property p_id_copy;
		@(posedge clk_sys_i) disable iff (!rst_q) tx_accept_o && !tx_new_id_i |=> tx_id_o == $past(tx_id_i);
	endproperty
	a_id_copy: assert property (p_id_copy) else $error("identifier not copied");
	property p_unknown_rej;
		@(posedge clk_sys_i) disable iff (!rst_q) c_rej |=> rej_pend_q && rej_reason_q == 16'h0000 && rej_id_q == $past(c_id);
	endproperty
	a_unknown_rej: assert property (p_unknown_rej) else $error("unknown code not rejected");
	property p_stray;
		@(posedge clk_sys_i) disable iff (!rst_q) chdr_done && c_stray |=> !cmd_valid_o ##1 !rej_pend_q || $past(rej_pend_q);
	endproperty
	a_stray: assert property (p_stray) else $error("stray response delivered");
	property p_psm_odd;
		@(posedge clk_sys_i) disable iff (!rst_q) psm_valid_o |-> psm_value_o[0] && !$past(psm_bad);
	endproperty
	a_psm_odd: assert property (p_psm_odd) else $error("even multiplexer accepted");
	property p_len_err;
		@(posedge clk_sys_i) disable iff (!rst_q) len_bad |=> pkt_err_o;
	endproperty
	a_len_err: assert property (p_len_err) else $error("length mismatch not flagged");
	property p_lim_rej;
		@(posedge clk_sys_i) disable iff (!rst_q) sig_end && !c_rej |=> rej_pend_q && rej_reason_q == 16'h0001;
	endproperty
	a_lim_rej: assert property (p_lim_rej) else $error("over-limit packet not rejected");
	c_rej_sent: cover property (@(posedge clk_sys_i) disable iff (!rst_q) take_rej);
	c_psm: cover property (@(posedge clk_sys_i) disable iff (!rst_q) psm_valid_o);
	c_dup: cover property (@(posedge clk_sys_i) disable iff (!rst_q) cmd_valid_o && cmd_dup_o);
	c_two_cmd: cover property (@(posedge clk_sys_i) disable iff (!rst_q) cmd_valid_o ##[1:40] cmd_valid_o);
endmodule : cpsf_framer

/* File: cpsf_peer_model.sv */
`timescale 1ns/10ps
module cpsf_peer_model (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic slow_i,
	input wire logic tx_valid_i,
	input wire logic tx_last_i,
	output logic tx_ready_o,
	output logic take_o
);
	logic [3:0] lfsr_q;
	// Stall pattern for a slow peer
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) lfsr_q <= 4'h1;
		else lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
	end
	assign tx_ready_o = !slow_i || lfsr_q[0];
	assign take_o = tx_valid_i && tx_ready_o;
endmodule : cpsf_peer_model

/* File: tb_channel_packet_signal_framer.sv */
`timescale 1ns/10ps
module tb_channel_packet_signal_framer;
	logic clk_sys_i = 0, rst_b_i = 0, rx_valid_i = 0, rx_first_i = 0, rx_last_i = 0, tx_start_i = 0, tx_cmd_i = 0;
	logic tx_new_id_i = 0, peer_sig_big_i = 0, tx_body_valid_i = 0, slow = 0;
	logic [7:0] rx_data_i = 0, tx_code_i = 0, tx_id_i = 0, tx_body_i = 0, cmd_code_o, cmd_id_o, pay_data_o, tx_id_o;
	logic [7:0] tx_data_o, id1, u;
	logic [15:0] tx_cid_i = 0, tx_len_i = 0, pkt_len_o, pkt_cid_o, cmd_len_o;
	logic [31:0] psm_value_o;
	logic pkt_start_o, pkt_err_o, psm_valid_o, cmd_valid_o, cmd_dup_o, pay_valid_o, tx_accept_o, tx_body_ready_o;
	logic tx_valid_o, tx_last_o, tx_ready_i, take;
	logic [31:0] q_hdr[$], q_cmd[$], q_tx[$], q_pay[$], q_psm[$], q_err[$], q_dup[$];
	logic [15:0] lreq = 0;
	logic lreq_v = 0;
	logic [7:0] b[$];
	int n_mismatch = 0, checks = 0;

	cpsf_framer #(.SEC_CYCLES(16)) dut (.clk_sys_i, .rst_b_i, .rx_valid_i, .rx_data_i, .rx_first_i, .rx_last_i,
		.pkt_start_o, .pkt_len_o, .pkt_cid_o, .pkt_err_o, .psm_valid_o, .psm_value_o, .cmd_valid_o, .cmd_code_o,
		.cmd_id_o, .cmd_len_o, .cmd_dup_o, .pay_valid_o, .pay_data_o, .tx_start_i, .tx_cmd_i, .tx_cid_i, .tx_len_i,
		.tx_code_i, .tx_id_i, .tx_new_id_i, .peer_sig_big_i, .tx_accept_o, .tx_id_o, .tx_body_valid_i, .tx_body_i,
		.tx_body_ready_o, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i);
	cpsf_peer_model peer (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
		.tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i), .take_o(take));

	initial forever #2 clk_sys_i = ~clk_sys_i;

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic pop(ref logic [31:0] q[$], input logic [31:0] seen);
		if (q.size() == 0) chk(seen, 32'hffff_ffff);
		else chk(seen, q.pop_front());
	endtask : pop

	task test_done;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done

	always @(posedge clk_sys_i) if (rst_b_i) begin
		if (pkt_start_o === 1'b1) pop(q_hdr, {pkt_cid_o, pkt_len_o});
		if (cmd_valid_o === 1'b1) pop(q_cmd, {cmd_code_o, cmd_id_o, cmd_len_o});
		if (cmd_valid_o === 1'b1) pop(q_dup, {31'h0, cmd_dup_o});
		if (pay_valid_o === 1'b1) pop(q_pay, {24'h0, pay_data_o});
		if (psm_valid_o === 1'b1) pop(q_psm, {16'h0, psm_value_o[15:0]});
		if (pkt_err_o === 1'b1) pop(q_err, 32'h1);
		if (take === 1'b1) pop(q_tx, {23'h0, tx_last_o, tx_data_o});
	end

	task automatic exp_tx(input logic [7:0] o[$]);
		foreach (o[i]) q_tx.push_back({23'h0, i == o.size() - 1, o[i]});
	endtask : exp_tx

	task automatic add_cmd(input logic [7:0] code, input logic [7:0] id, input int n, input logic dlv);
		logic [7:0] v;
		logic rq;
		rq = code inside {8'h02, 8'h04, 8'h06, 8'h08, 8'h0a};
		b = {b, code, id, 8'(n), 8'(n >> 8)};
		if (dlv) begin
			q_cmd.push_back({code, id, 16'(n)});
			q_dup.push_back({31'h0, rq && lreq_v && lreq == {code, id}});
			if (rq) begin
				lreq_v = 1;
				lreq = {code, id};
			end
		end
		repeat (n) begin
			v = 8'($urandom);
			b.push_back(v);
			if (dlv) q_pay.push_back({24'h0, v});
		end
	endtask : add_cmd

	// Peer side of the receive path; data line inverted when idle
	task automatic send_rx(input logic [15:0] channel_endpoint_id, input int extra);
		logic [7:0] f[$];
		logic [15:0] len;
		len = 16'(b.size() + extra);
		q_hdr.push_back({channel_endpoint_id, len});
		f = {len[7:0], len[15:8], channel_endpoint_id[7:0], channel_endpoint_id[15:8], b};
		foreach (f[i]) begin
			rx_valid_i <= 1;
			rx_data_i <= f[i];
			rx_first_i <= (i == 0);
			rx_last_i <= (i == f.size() - 1);
			@(posedge clk_sys_i);
		end
		rx_valid_i <= 0;
		rx_last_i <= 0;
		rx_data_i <= ~f[f.size() - 1];
		repeat (50) @(posedge clk_sys_i);
	endtask : send_rx

	task automatic send_tx(input logic cmd, input logic nid, input logic [15:0] channel_endpoint_id, input logic [7:0] code,
		input logic [7:0] id, output logic [7:0] idu);
		int k;
		logic [15:0] n;
		n = 16'(b.size());
		tx_start_i <= 1;
		tx_cmd_i <= cmd;
		tx_cid_i <= channel_endpoint_id;
		tx_len_i <= n;
		tx_code_i <= code;
		tx_id_i <= id;
		tx_new_id_i <= nid;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (tx_accept_o !== 1'b1 && k < 100);
		chk({31'h0, tx_accept_o}, 32'h1);
		tx_start_i <= 0;
		@(posedge clk_sys_i);
		idu = nid ? tx_id_o : id;
		if (cmd) exp_tx({8'(n + 4), 8'((n + 4) >> 8), 8'h01, 8'h00, code, idu, n[7:0], n[15:8], b});
		else exp_tx({n[7:0], n[15:8], channel_endpoint_id[7:0], channel_endpoint_id[15:8], b});
		foreach (b[i]) begin
			tx_body_valid_i <= 1;
			tx_body_i <= b[i];
			do @(posedge clk_sys_i); while (tx_body_ready_o !== 1'b1);
		end
		tx_body_valid_i <= 0;
		while (q_tx.size() != 0) @(posedge clk_sys_i);
		repeat (4) @(posedge clk_sys_i);
	endtask : send_tx

	initial begin
		#100000;
		n_mismatch++;
		test_done();
	end

	initial begin
		void'($urandom(24962));
		repeat (4) @(posedge clk_sys_i);
		rst_b_i <= 1;
		repeat (8) @(posedge clk_sys_i);
		add_cmd(8'h08, 8'h05, 2, 1);
		add_cmd(8'h0a, 8'h06, 0, 1);
		add_cmd(8'h0a, 8'h06, 0, 1);
		send_rx(cpsf_pkg::CID_SIG, 0);
		for (int c = 0; c <= 13; c++) begin
			b.delete();
			add_cmd(c == 13 ? 8'h08 : 8'(c), c == 13 ? 8'h00 : 8'(c + 1), 0, c inside {2, 4, 6, 8, 10});
			if (c == 0 || c == 12) exp_tx({8'h06, 8'h00, 8'h01, 8'h00, 8'h01, 8'(c + 1), 8'h02, 8'h00, 8'h00, 8'h00});
			send_rx(cpsf_pkg::CID_SIG, 0);
		end
		b.delete();
		add_cmd(8'h08, 8'h09, 48, 0);
		exp_tx({8'h08, 8'h00, 8'h01, 8'h00, 8'h01, 8'h09, 8'h04, 8'h00, 8'h01, 8'h00, 8'h30, 8'h00});
		send_rx(cpsf_pkg::CID_SIG, 0);
		b = {8'h03, 8'h00};
		q_psm.push_back(32'h3);
		repeat (670) begin
			u = 8'($urandom);
			b.push_back(u);
			q_pay.push_back({24'h0, u});
		end
		send_rx(cpsf_pkg::CID_GRP, 0);
		b = {8'h02, 8'h00, 8'h11};
		q_err.push_back(32'h1);
		send_rx(cpsf_pkg::CID_GRP, 0);
		b = {8'(3 + $urandom % 200), 8'h5a};
		foreach (b[i]) q_pay.push_back({24'h0, b[i]});
		q_err.push_back(32'h1);
		send_rx(16'h0040, 1);
		slow <= 1;
		b = {8'(~3), 8'($urandom), 8'h7e};
		send_tx(0, 0, {8'h40, 8'($urandom)}, 8'h00, 8'h00, u);
		b.delete();
		send_tx(1, 1, 16'h0, cpsf_pkg::CODE_ECHO_REQ, 8'h00, id1);
		send_tx(1, 1, 16'h0, cpsf_pkg::CODE_INFO_REQ, 8'h00, u);
		chk({31'h0, u != 0 && id1 != 0 && u != id1}, 32'h1);
		send_tx(1, 0, 16'h0, cpsf_pkg::CODE_ECHO_REQ, id1, u);
		add_cmd(cpsf_pkg::CODE_ECHO_RSP, id1, 0, 1);
		send_rx(cpsf_pkg::CID_SIG, 0);
		tx_start_i <= 1;
		tx_cmd_i <= 1;
		tx_len_i <= 16'h2d;
		tx_new_id_i <= 1;
		repeat (3) begin
			@(posedge clk_sys_i);
			chk({31'h0, tx_accept_o}, 32'h0);
		end
		tx_start_i <= 0;
		repeat (50) @(posedge clk_sys_i);
		chk(q_hdr.size() + q_cmd.size() + q_tx.size() + q_pay.size() + q_psm.size() + q_err.size() + q_dup.size(), 0);
		test_done();
	end
endmodule : tb_channel_packet_signal_framer
